// ### spcwl_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants of the configuration word loader.
// ---------------------------------------------------------------------------
package spcwl_pkg;

   // Bus and word widths.
   localparam int ADDR_W  = 14;
   localparam int DATA_W  = 32;
   localparam int WORD_W  = 16;
   localparam int WADDR_W = 8;

   // Preset word addresses handled by this block.
   localparam logic [7:0] W_NSR3   = 8'h55;
   localparam logic [7:0] W_PMCAP3 = 8'h56;
   localparam logic [7:0] W_PMDAT3 = 8'h57;
   localparam logic [7:0] W_PORT0  = 8'h60;
   localparam logic [7:0] W_PORT1  = 8'h62;
   localparam logic [7:0] W_PORT2  = 8'h64;

   // Configuration offsets inside one port's space.
   localparam logic [11:0] OFS_PMCAP   = 12'h040;
   localparam logic [11:0] OFS_PMDAT   = 12'h044;
   localparam logic [11:0] OFS_SLOTCAP = 12'h0C0;
   localparam logic [11:0] OFS_PORTNUM = 12'h0CC;
   localparam logic [11:0] OFS_SLOTCLK = 12'h0D0;
   localparam logic [11:0] OFS_LPVC    = 12'h144;
   localparam logic [11:0] OFS_TCMAP   = 12'h154;
   localparam logic [11:0] OFS_LCTRL   = 12'h800;
   localparam logic [11:0] OFS_LSTAT   = 12'h804;

   // Field positions in the configuration registers.
   localparam int POS_DSI     = 21;
   localparam int POS_AUX     = 22;
   localparam int POS_D1      = 25;
   localparam int POS_D2      = 26;
   localparam int POS_PME     = 28;
   localparam int POS_PMDATA  = 24;
   localparam int POS_NSR     = 3;
   localparam int POS_SLOTIMP = 24;
   localparam int POS_PORTNUM = 24;
   localparam int POS_SLOTCLK = 28;
   localparam int POS_LPVC    = 4;
   localparam int POS_TCMAP   = 1;
   localparam int POS_TC0     = 0;

   // Field positions in the preset words.
   localparam int WB_SLOTIMP = 0;
   localparam int WB_NSR     = 0;
   localparam int WB_SLOTCLK = 1;
   localparam int WB_DSI     = 2;
   localparam int WB_LPVC    = 3;
   localparam int WB_AUX_LO  = 1;
   localparam int WB_PME_LO  = 6;
   localparam int WB_PN_LO   = 4;
   localparam int WB_TC_LO   = 9;
   localparam int WB_DAT_LO  = 8;

   // Values after reset.
   localparam logic [2:0] RST_AUX    = 3'h0;
   localparam logic [1:0] RST_PME    = 2'h0;
   localparam logic [7:0] RST_PMDATA = 8'h00;
   localparam logic [6:0] RST_TCMAP  = 7'h00;
   localparam logic [7:0] RST_COUNT  = 8'h00;

   // Loader states, Gray coded.
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_DONE = 2'b01
   } spcwl_state_t;

endpackage

// ### spcwl_word_decode.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Turns an incoming preset word address into one load strobe per target.
// ---------------------------------------------------------------------------
module spcwl_word_decode
   import spcwl_pkg::*;
(
   input  wire logic               word_ok,
   input  wire logic [WADDR_W-1:0] word_addr,
   output logic                    nsr3_stb,
   output logic                    pmcap3_stb,
   output logic                    pmdat3_stb,
   output logic [2:0]              port_stb
);

   // Each strobe is qualified by the gated valid from the sequencer.
   assign nsr3_stb    = word_ok && (word_addr == W_NSR3);
   assign pmcap3_stb  = word_ok && (word_addr == W_PMCAP3);
   assign pmdat3_stb  = word_ok && (word_addr == W_PMDAT3);
   assign port_stb[0] = word_ok && (word_addr == W_PORT0);
   assign port_stb[1] = word_ok && (word_addr == W_PORT1);
   assign port_stb[2] = word_ok && (word_addr == W_PORT2);

endmodule

// ### spcwl_port_fields.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Holds the per-port fields that one per-port preset word loads.
// ---------------------------------------------------------------------------
module spcwl_port_fields
   import spcwl_pkg::*;
#(
   parameter logic       HAS_SLOT = 1'b1,
   parameter logic [2:0] RST_PN   = 3'h0
)(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              load_stb,
   input  wire logic [WORD_W-1:0] word_data,
   output logic                   slot_imp_q,
   output logic                   slot_clk_q,
   output logic                   dsi_q,
   output logic                   lpvc_q,
   output logic [2:0]             portnum_q,
   output logic [6:0]             tcmap_q
);

   // The slot bit exists only where the port may carry a slot.
   logic slot_imp_d;
   assign slot_imp_d = HAS_SLOT & word_data[WB_SLOTIMP];

   // Fields keep their reset value until a preset word arrives.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         slot_imp_q <= 1'b0;
         slot_clk_q <= 1'b0;
         dsi_q      <= 1'b0;
         lpvc_q     <= 1'b0;
         portnum_q  <= RST_PN;
         tcmap_q    <= RST_TCMAP;
      end
      else if (load_stb)
      begin
         slot_imp_q <= slot_imp_d;
         slot_clk_q <= word_data[WB_SLOTCLK];
         dsi_q      <= word_data[WB_DSI];
         lpvc_q     <= word_data[WB_LPVC];
         portnum_q  <= word_data[WB_PN_LO+:3];
         tcmap_q    <= word_data[WB_TC_LO+:7];
      end
   end

endmodule

// ### spcwl_loader.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Configuration word loader: sequencer, port 3 PM fields, config port.
// ---------------------------------------------------------------------------
module spcwl_loader
   import spcwl_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               word_valid,
   input  wire logic [WADDR_W-1:0] word_addr,
   input  wire logic [WORD_W-1:0]  word_data,
   input  wire logic               load_end,
   input  wire logic [ADDR_W-1:0]  cfg_addr,
   input  wire logic [DATA_W-1:0]  cfg_wdata,
   input  wire logic               cfg_wr,
   input  wire logic               cfg_rd,
   output logic [DATA_W-1:0]       cfg_rdata,
   output logic                    cfg_ready
);

   // ------------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------------

   spcwl_state_t state_q;      // Current loader state.
   spcwl_state_t state_d;      // Next loader state.
   logic         word_ok;      // Preset word accepted this cycle.
   logic         reload_req;   // Software asks for a fresh load window.
   logic [7:0]   count_q;      // Preset words applied since the window.
   logic [7:0]   count_d;      // Next value of the word counter.
   logic         any_stb;      // Some target took the current word.

   // Words are taken only while the load window is open, so late words
   // from a slow source cannot disturb fields software may be reading.
   assign word_ok    = word_valid && (state_q == ST_LOAD);
   assign reload_req = cfg_wr && (cfg_addr[11:0] == OFS_LCTRL)
                       && (cfg_addr[13:12] == 2'd0) && cfg_wdata[0];

   // Next state: the source marks the end of its scan with load_end.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_LOAD:
         begin
            if (load_end)
               state_d = ST_DONE;
         end
         ST_DONE:
         begin
            if (reload_req)
               state_d = ST_LOAD;
         end
         default:
            state_d = ST_LOAD;
      endcase
   end

   // The counter restarts whenever a new load window opens.
   assign count_d = (state_q == ST_DONE && reload_req) ? RST_COUNT :
                    (any_stb ? count_q + 8'h01 : count_q);

   // State register and word counter.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q <= ST_LOAD;
         count_q <= RST_COUNT;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   // Configuration accesses to port registers wait for the load to end.
   assign cfg_ready = (state_q == ST_DONE);

   // ------------------------------------------------------------------------
   // Word decode and per-port fields
   // ------------------------------------------------------------------------

   logic       nsr3_stb;      // Word carrying the port 3 no-soft-reset.
   logic       pmcap3_stb;    // Word carrying port 3 PM capability.
   logic       pmdat3_stb;    // Word carrying port 3 PM data.
   logic [2:0] port_stb;      // Per-port words for ports 0 to 2.
   logic [3:0] slot_imp;      // Slot implemented, per port.
   logic [3:0] slot_clk;      // Connector clock in use, per port.
   logic [3:0] dsi;           // Device-specific init required, per port.
   logic [3:0] lpvc;          // VC1 in low-priority group, per port.
   logic [2:0] portnum [4];   // Logical port number, per port.
   logic [6:0] tcmap   [4];   // TC to VC0 map bits 7:1, per port.

   spcwl_word_decode u_dec (
      .word_ok    (word_ok),
      .word_addr  (word_addr),
      .nsr3_stb   (nsr3_stb),
      .pmcap3_stb (pmcap3_stb),
      .pmdat3_stb (pmdat3_stb),
      .port_stb   (port_stb)
   );

   assign any_stb = nsr3_stb | pmcap3_stb | pmdat3_stb | (|port_stb);

   // Ports 0 to 2 each own one per-port word; port 0 has no slot.
   for (genvar p = 0; p < 3; p++)
   begin : g_port
      spcwl_port_fields #(
         .HAS_SLOT (p != 0),
         .RST_PN   (3'(p))
      ) u_fld (
         .clk        (clk),
         .sys_rst    (sys_rst),
         .load_stb   (port_stb[p]),
         .word_data  (word_data),
         .slot_imp_q (slot_imp[p]),
         .slot_clk_q (slot_clk[p]),
         .dsi_q      (dsi[p]),
         .lpvc_q     (lpvc[p]),
         .portnum_q  (portnum[p]),
         .tcmap_q    (tcmap[p])
      );
   end

   // Port 3's per-port word is handled elsewhere; it reads defaults here.
   assign slot_imp[3] = 1'b0;
   assign slot_clk[3] = 1'b0;
   assign dsi[3]      = 1'b0;
   assign lpvc[3]     = 1'b0;
   assign portnum[3]  = 3'h3;
   assign tcmap[3]    = RST_TCMAP;

   // ------------------------------------------------------------------------
   // Port 3 power-management fields
   // ------------------------------------------------------------------------

   logic [2:0] aux3_q;     // Auxiliary current.
   logic [1:0] pme3_q;     // PME support for D2 and D1.
   logic [7:0] pmdat3_q;   // Read-only PM data byte.
   logic       nsr3_q;     // No soft reset indication.

   // Each field loads only from its own word; others keep their value.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         aux3_q   <= RST_AUX;
         pme3_q   <= RST_PME;
         pmdat3_q <= RST_PMDATA;
         nsr3_q   <= 1'b0;
      end
      else
      begin
         if (pmcap3_stb)
         begin
            aux3_q <= word_data[WB_AUX_LO+:3];
            pme3_q <= word_data[WB_PME_LO+:2];
         end
         if (pmdat3_stb)
            pmdat3_q <= word_data[WB_DAT_LO+:8];
         if (nsr3_stb)
            nsr3_q <= word_data[WB_NSR];
      end
   end

   // ------------------------------------------------------------------------
   // Configuration read port
   // ------------------------------------------------------------------------

   logic [1:0]        rd_port;    // Port addressed by the access.
   logic [11:0]       rd_ofs;     // Offset inside that port's space.
   logic              is_p3;      // Access targets port 3.
   logic [DATA_W-1:0] pmcap_w;    // PM capability read word.
   logic [DATA_W-1:0] pmdat_w;    // PM control and data read word.
   logic [DATA_W-1:0] lstat_w;    // Loader status word.
   logic [DATA_W-1:0] port_w;     // Selected port register word.
   logic [DATA_W-1:0] rdata_d;    // Read data for the next cycle.
   logic [DATA_W-1:0] rdata_q;    // Registered read data.

   assign rd_port = cfg_addr[13:12];
   assign rd_ofs  = cfg_addr[11:0];
   assign is_p3   = (rd_port == 2'd3);

   // D1 and D2 support are fixed at one whatever the preset word holds.
   assign pmcap_w = (32'(dsi[rd_port]) << POS_DSI)
                  | (32'(is_p3 ? aux3_q : RST_AUX) << POS_AUX)
                  | (32'h0000_0001 << POS_D1)
                  | (32'h0000_0001 << POS_D2)
                  | (32'(is_p3 ? pme3_q : RST_PME) << POS_PME);
   assign pmdat_w = (32'(is_p3 ? pmdat3_q : RST_PMDATA) << POS_PMDATA)
                  | (32'(is_p3 & nsr3_q) << POS_NSR);
   assign lstat_w = {16'h0000, count_q, 7'h00, cfg_ready};

   // Register select; TC0 is always mapped into VC0.
   assign port_w =
      (rd_ofs == OFS_PMCAP)   ? pmcap_w :
      (rd_ofs == OFS_PMDAT)   ? pmdat_w :
      (rd_ofs == OFS_SLOTCAP) ? 32'(slot_imp[rd_port]) << POS_SLOTIMP :
      (rd_ofs == OFS_PORTNUM) ? 32'(portnum[rd_port]) << POS_PORTNUM :
      (rd_ofs == OFS_SLOTCLK) ? 32'(slot_clk[rd_port]) << POS_SLOTCLK :
      (rd_ofs == OFS_LPVC)    ? 32'(lpvc[rd_port]) << POS_LPVC :
      (rd_ofs == OFS_TCMAP)   ? (32'(tcmap[rd_port]) << POS_TCMAP)
                                | (32'h0000_0001 << POS_TC0) :
      32'h0000_0000;

   // Status stays readable during loading so software can poll it;
   // port registers read as zero until the load has finished.
   assign rdata_d = !cfg_rd ? 32'h0000_0000 :
                    (rd_ofs == OFS_LSTAT && rd_port == 2'd0) ? lstat_w :
                    cfg_ready ? port_w : 32'h0000_0000;

   // Read data stands in the cycle after the strobe and only there.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= 32'h0000_0000;
      else
         rdata_q <= rdata_d;
   end

   assign cfg_rdata = rdata_q;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------

   aux_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      pmcap3_stb |=> aux3_q == $past(word_data[3:1]))
      else $error("aux current not loaded from word bits 3:1");

   d1_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_ready && rd_ofs == OFS_PMCAP |=> cfg_rdata[25])
      else $error("D1 support bit did not read as one");

   d2_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_ready && rd_ofs == OFS_PMCAP |=> cfg_rdata[26])
      else $error("D2 support bit did not read as one");

   pme_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      pmcap3_stb |=> pme3_q == $past(word_data[7:6]))
      else $error("PME support not loaded from word bits 7:6");

   pm_data_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && cfg_ready && rd_ofs == OFS_PMDAT && is_p3
      |=> cfg_rdata[31:24] == pmdat3_q)
      else $error("PM data byte read back wrong");

   nsr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      nsr3_stb ##1 (!nsr3_stb)[*2] |-> nsr3_q == $past(word_data[0], 2))
      else $error("no soft reset not held from its word");

   slot_clk_a: assert property (@(posedge clk) disable iff (sys_rst)
      port_stb[1] |=> slot_clk[1] == $past(word_data[1]))
      else $error("slot clock bit not loaded");

   dsi_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      port_stb[2] |=> dsi[2] == $past(word_data[2]))
      else $error("DSI bit not loaded");

   lpvc_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      port_stb[0] |=> lpvc[0] == $past(word_data[3]))
      else $error("low priority VC bit not loaded");

   port_num_a: assert property (@(posedge clk) disable iff (sys_rst)
      port_stb[1] |=> portnum[1] == $past(word_data[6:4]))
      else $error("logical port number not loaded");

   tc_map_a: assert property (@(posedge clk) disable iff (sys_rst)
      port_stb[2] |=> tcmap[2] == $past(word_data[15:9]))
      else $error("TC map not loaded from bits 15:9");

   slot_p0_a: assert property (@(posedge clk) disable iff (sys_rst)
      port_stb[0] |=> !slot_imp[0])
      else $error("port 0 reported a slot");

   locked_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_rd && !cfg_ready && rd_ofs != OFS_LSTAT |=> cfg_rdata == 0)
      else $error("port register readable before load end");

   // Read data must fall back to zero once its single cycle is over.
   rd_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg_rd |=> cfg_rdata == 32'h0000_0000)
      else $error("read data stood outside its cycle");

   // Once loading is over, late words must not advance the word counter.
   done_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_ready && !reload_req |=> $stable(count_q))
      else $error("word applied after the load had ended");

endmodule

// ### spcwl_eeprom_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Preset memory model: replays eight words, then flags the end of the scan.
// ---------------------------------------------------------------------------
module spcwl_eeprom_model
   import spcwl_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   start,
   input  wire logic                   slow,
   input  wire logic [7:0][WORD_W-1:0] img,
   output logic                        word_valid,
   output logic [WADDR_W-1:0]          word_addr,
   output logic [WORD_W-1:0]           word_data,
   output logic                        load_end
);
   // Scan order; 58h is unknown and 60h repeats, so the last one must win.
   logic [7:0][7:0] addr_tab;
   int              i;

   assign addr_tab = {8'h60, 8'h58, 8'h64, 8'h62, 8'h60, 8'h57, 8'h56, 8'h55};

   initial
   begin
      word_valid = 1'b0;
      word_addr  = 8'h00;
      word_data  = 16'h0000;
      load_end   = 1'b0;
   end

   // One scan per start pulse; slow mode leaves two idle cycles per word.
   // Idle lines show the inverse of the last word, never a held copy.
   always
   begin
      @(posedge clk);
      if (start && !sys_rst)
      begin
         for (i = 0; i < 8; i++)
         begin
            word_valid <= 1'b1;
            word_addr  <= addr_tab[i];
            word_data  <= img[i];
            @(posedge clk);
            if (slow)
            begin
               word_valid <= 1'b0;
               word_addr  <= ~addr_tab[i];
               word_data  <= ~img[i];
               repeat (2) @(posedge clk);
            end
         end
         if (!slow)
         begin
            word_valid <= 1'b0;
            word_addr  <= ~addr_tab[7];
            word_data  <= ~img[7];
         end
         load_end <= 1'b1;
         @(posedge clk);
         load_end <= 1'b0;
      end
   end
endmodule

// ### spcwl_loader_tb_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Self-checking bench for the configuration word loader.
// ---------------------------------------------------------------------------
module spcwl_loader_tb_top
   import spcwl_pkg::*;
;
   logic                   clk;
   logic                   sys_rst;
   logic                   start;
   logic                   slow;
   logic [7:0][WORD_W-1:0] img;
   logic                   word_valid;
   logic [WADDR_W-1:0]     word_addr;
   logic [WORD_W-1:0]      word_data;
   logic                   load_end;
   logic [ADDR_W-1:0]      cfg_addr;
   logic [DATA_W-1:0]      cfg_wdata;
   logic                   cfg_wr;
   logic                   cfg_rd;
   logic [DATA_W-1:0]      cfg_rdata;
   logic                   cfg_ready;
   int                     failures;
   int                     total_checks;
   // Two images, the second the inverse, so every stored bit must toggle.
   logic [7:0][WORD_W-1:0] img_a;

   assign img_a = {16'h3347, 16'hFFFF, 16'h8E5C, 16'h5A2B,
                   16'hFFFF, 16'hA53C, 16'h00FE, 16'h0001};

   spcwl_eeprom_model i_spcwl_eeprom_model (.clk(clk), .sys_rst(sys_rst),
      .start(start), .slow(slow), .img(img), .word_valid(word_valid),
      .word_addr(word_addr), .word_data(word_data), .load_end(load_end));

   spcwl_loader i_spcwl_loader (.clk(clk), .sys_rst(sys_rst),
      .word_valid(word_valid), .word_addr(word_addr), .word_data(word_data),
      .load_end(load_end), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
      .cfg_ready(cfg_ready));

   // ------------------------------------------------------------------------
   // Clock and shared tasks.
   // ------------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic cfg_read(input logic [13:0] a, output logic [31:0] d);
      @(posedge clk);
      cfg_rd   <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1 d = cfg_rdata;
   endtask

   task automatic cfg_write(input logic [13:0] a, input logic [31:0] d);
      @(posedge clk);
      cfg_wr    <= 1'b1;
      cfg_addr  <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask

   // Expected register contents worked out from a scanned image.
   function automatic logic [31:0] exp_reg(int p, logic [11:0] o,
                                           logic [7:0][15:0] m);
      logic [15:0] w;
      logic [31:0] r;
      w = (p == 0) ? m[7] : (p == 1) ? m[4] : m[5];
      r = 32'h0000_0000;
      case (o)
         12'h040:
         begin
            r[26:25] = 2'b11;
            if (p == 3)
            begin
               r[24:22] = m[1][3:1];
               r[29:28] = m[1][7:6];
            end
            else
               r[21] = w[2];
         end
         12'h044:
            if (p == 3)
               r = {m[2][15:8], 20'h0_0000, m[0][0], 3'h0};
         12'h0C0: r[24] = (p == 1 || p == 2) ? w[0] : 1'b0;
         12'h0CC: r[26:24] = (p == 3) ? 3'h3 : w[6:4];
         12'h0D0: r[28] = (p < 3) ? w[1] : 1'b0;
         12'h144: r[4] = w[3];
         default: r[7:0] = {w[15:9], 1'b1};
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------------------
   // Before any scan, port registers and the status word read zero.
   task automatic t_reset();
      logic [31:0] d;
      cfg_read(14'h3040, d);
      check("cap3 before load", 32'h0000_0000, d);
      cfg_read(14'h0804, d);
      check("status before load", 32'h0000_0000, d);
      $display("test reset done");
   endtask

   // Runs one scan, checks the ready timing, then every loaded field.
   task automatic t_load(input logic [7:0][15:0] m, input logic s);
      logic [31:0]      d;
      logic [11:0]      o;
      logic [6:0][11:0] ofs;
      int               n;
      logic [31:0]      e;
      string            nm;
      ofs = {12'h154, 12'h144, 12'h0D0, 12'h0CC, 12'h0C0, 12'h044, 12'h040};
      n = 0;
      img   <= m;
      slow  <= s;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      while (load_end !== 1'b1)
      begin
         n++;
         if (n > 200)
         begin
            failures++;
            end_of_test();
         end
         @(posedge clk);
         #1;
      end
      check("ready during load", 32'h0000_0000, 32'(cfg_ready));
      @(posedge clk);
      #1 check("ready after end", 32'h0000_0001, 32'(cfg_ready));
      for (int p = 0; p < 4; p++)
         for (int k = 0; k < 7; k++)
         begin
            o = ofs[k];
            if (p == 3 && k > 4)
               continue;
            cfg_read({p[1:0], o}, d);
            e  = exp_reg(p, o, m);
            nm = $sformatf("port %0d reg %h", p, o);
            if (p == 3)
               check(nm, e, d);
            else
               check(nm, e, d);
         end
      cfg_read(14'h0804, d);
      check("status count", 32'h0000_0701, d);
      $display("test load done");
   endtask

   // Fields are read-only; a control write outside port 0 is ignored.
   // A late scan of the inverse image after the load has ended must
   // leave the port 0 TC map and the word count untouched.
   task automatic t_write_ignored(input logic [7:0][15:0] m);
      logic [31:0] d;
      img   <= ~m;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (12) @(posedge clk);
      cfg_read(14'h0154, d);
      check("tcmap after late scan", exp_reg(0, 12'h154, m), d);
      cfg_write(14'h3040, 32'hFFFF_FFFF);
      cfg_write(14'h1800, 32'h0000_0001);
      cfg_read(14'h3040, d);
      check("cap3 after write", exp_reg(3, 12'h040, m), d);
      cfg_read(14'h0804, d);
      check("status after write", 32'h0000_0701, d);
      $display("test write done");
   endtask

   // Reopening hides the port registers until the next scan completes.
   task automatic t_reopen();
      logic [31:0] d;
      cfg_write(14'h0800, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1 check("ready reopened", 32'h0000_0000, 32'(cfg_ready));
      cfg_read(14'h1154, d);
      check("tcmap hidden", 32'h0000_0000, d);
      t_load(~img_a, 1'b1);
      $display("test reopen done");
   endtask

   // ------------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------------
   initial
   begin
      failures     = 0;
      total_checks = 0;
      sys_rst      = 1'b1;
      start        = 1'b0;
      slow         = 1'b0;
      img          = '0;
      cfg_addr     = 14'h0000;
      cfg_wdata    = 32'h0000_0000;
      cfg_wr       = 1'b0;
      cfg_rd       = 1'b0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_load(img_a, 1'b0);
      t_write_ignored(img_a);
      t_reopen();
      end_of_test();
   end
endmodule
